// ===== verilog/vcp_pkg.sv
// Constants shared by the velocity command processor and its ramp stage.
// Assumes a single 20 MHz control clock.
`default_nettype none

package vcp_pkg;
  // Clock and control period
  localparam int CLK_HZ         = 20_000_000;
  localparam int CLK_PERIOD_NS  = 1_000_000_000 / CLK_HZ;
  localparam int CTRL_PERIOD_NS = 100_000;                        // Speed loop update period
  localparam int CTRL_CYC       = CTRL_PERIOD_NS / CLK_PERIOD_NS; // Clock cycles per period
  localparam int FILT_UNIT_NS   = 10_000;                         // Filter time constant unit
  localparam int FILT_STEP      = CTRL_PERIOD_NS / FILT_UNIT_NS;  // Filter units per period
  localparam int MS_NS          = 1_000_000;
  localparam int MS_PER         = MS_NS / CTRL_PERIOD_NS;         // Periods per millisecond
  localparam int RATE_SPD       = 1000;                           // Speed change per ramp time
  localparam int FRAC_BITS      = 8;                              // Fraction bits of ramp state
  localparam int RAMP_NUM       = (RATE_SPD << FRAC_BITS) / MS_PER;
  // Analog scaling: one input step is 359 uV
  localparam int ANA_LSB_UV     = 359;
  localparam int UV_PER_V       = 1_000_000;
  localparam int SCALE_SH       = 20;
  localparam int SCALE_Q        = (ANA_LSB_UV << SCALE_SH) / UV_PER_V;
  localparam int SPD_MAX        = 20_000;
  // Register offsets (byte addresses)
  localparam logic [7:0] A_CTRL   = 8'h00;
  localparam logic [7:0] A_GAIN   = 8'h04;
  localparam logic [7:0] A_OFFS   = 8'h08;
  localparam logic [7:0] A_FILT   = 8'h0C;
  localparam logic [7:0] A_ZTHR   = 8'h10;
  localparam logic [7:0] A_MATCH  = 8'h14;
  localparam logic [7:0] A_ATTAIN = 8'h18;
  localparam logic [7:0] A_ACCEL  = 8'h1C;
  localparam logic [7:0] A_DECEL  = 8'h20;
  localparam logic [7:0] A_SCURVE = 8'h24;
  localparam logic [7:0] A_STATUS = 8'h28;
  localparam logic [7:0] A_CMD    = 8'h2C;
  localparam logic [7:0] A_INT0   = 8'h40;
  // Control register fields
  localparam int CF_SRC  = 0;
  localparam int CF_DIR  = 2;
  localparam int CF_INV  = 3;
  localparam int CF_ZM   = 4;
  localparam int CF_MSRC = 6;
  localparam int CTRL_W  = 7;
  // Speed source and zero clamp codes
  localparam logic [1:0] SRC_ANALOG = 2'h0;
  localparam logic [1:0] SRC_INT4   = 2'h1;
  localparam logic [1:0] SRC_INT7   = 2'h2;
  localparam logic [1:0] SRC_INT8   = 2'h3;
  localparam logic [1:0] ZM_OFF     = 2'h0;
  localparam logic [1:0] ZM_MOTOR   = 2'h2;
  localparam logic [1:0] ZM_CMD     = 2'h3;
  // Values after reset
  localparam logic [CTRL_W-1:0] RST_CTRL = 7'h00;
  localparam logic [10:0] RST_GAIN   = 11'h1F4;
  localparam logic [14:0] RST_MATCH  = 15'h0032;
  localparam logic [14:0] RST_ATTAIN = 15'h03E8;
endpackage : vcp_pkg

`default_nettype wire

// ===== verilog/vcp_ramp_if.sv
// Connection between the command selector and the ramp stage.
// Assumes both ends share one clock.
`default_nettype none

interface vcp_ramp_if;
  logic               tick;    // One pulse per control period
  logic signed [15:0] target;  // Command before ramping
  logic [13:0]        accel;   // Acceleration time, ms per 1000 r/min
  logic [13:0]        decel;   // Deceleration time, ms per 1000 r/min
  logic [9:0]         scurve;  // S-curve time, ms
  logic signed [15:0] speed;   // Command after ramping
  modport ctl (output tick, target, accel, decel, scurve, input speed);
  modport rmp (input tick, target, accel, decel, scurve, output speed);
endinterface : vcp_ramp_if

`default_nettype wire

// ===== verilog/vcp_ramp.sv
// Acceleration/deceleration ramp with S-curve rounding.
// Assumes tick is one clock wide and at least ten clocks apart.
`default_nettype none

module vcp_ramp
  import vcp_pkg::*;
(
  input  wire logic i_clk,
  input  wire logic i_rst_b,
  vcp_ramp_if.rmp   rif
);
  logic signed [23:0] ramp_r, ramp_nxt;  // Linear ramp, fractional
  logic signed [23:0] sc_r, sc_nxt;      // Rounded output, fractional
  logic signed [23:0] tq;                // Target in ramp units
  logic               rising;            // Target above ramp
  logic [13:0]        rate;              // Time that applies now
  logic signed [31:0] step;              // Allowed change per period
  logic signed [31:0] d_ramp, d_sc, sc_div;

  ////////////////////////////////////////////////////////////////////////
  // Next ramp and S-curve values, once per period
  always_comb begin
    tq       = 24'(rif.target) <<< FRAC_BITS;
    rising   = tq > ramp_r;
    // Moving away from zero accelerates, toward zero decelerates
    if (rising) begin
      rate = (ramp_r >= 0) ? rif.accel : rif.decel;
    end else begin
      rate = (ramp_r <= 0) ? rif.accel : rif.decel;
    end
    step     = (rate == 14'h0000) ? 32'sh0 : RAMP_NUM / 32'(rate);
    d_ramp   = 32'(tq) - 32'(ramp_r);
    ramp_nxt = ramp_r;
    if (rif.tick) begin
      if (rate == 14'h0000) begin
        ramp_nxt = tq;                             // Zero time: no limit
      end else if (rising && d_ramp > step) begin
        ramp_nxt = ramp_r + 24'(step);
      end else if (!rising && -d_ramp > step) begin
        ramp_nxt = ramp_r - 24'(step);
      end else begin
        ramp_nxt = tq;
      end
    end
    // S-curve is a lag on the ramp; it softens both corners
    sc_div = 32'(rif.scurve) * MS_PER;
    d_sc   = 32'(ramp_r) - 32'(sc_r);
    sc_nxt = sc_r;
    if (rif.tick) begin
      if (rif.scurve == 10'h000) begin
        sc_nxt = ramp_nxt;
      end else if (d_sc / sc_div == 0) begin
        sc_nxt = ramp_r;                           // Last residue snaps in
      end else begin
        sc_nxt = sc_r + 24'(d_sc / sc_div);
      end
    end
  end

  // Ramp registers
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ramp_r <= 24'sh000000;
      sc_r   <= 24'sh000000;
    end else begin
      ramp_r <= ramp_nxt;
      sc_r   <= sc_nxt;
    end
  end

  assign rif.speed = 16'(sc_r >>> FRAC_BITS);

  ////////////////////////////////////////////////////////////////////////
  // Checks
  ramp_step_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    rif.tick && rising && rate != 14'h0000 |=>
      ramp_r > $past(ramp_r) && ramp_r - $past(ramp_r) <= $past(step))
    else $error("ramp rose faster than the set time allows");
  ramp_hold_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    !rif.tick |=> $stable(ramp_r) && $stable(sc_r))
    else $error("ramp moved between control periods");
endmodule : vcp_ramp

`default_nettype wire

// ===== verilog/vcp_core.sv
// Velocity command processor: analog or stored speed, clamp, ramp, status.
// Assumes sampled analog codes and contact inputs synchronous to I_CLK.
//
// Overview of operation
// - Sampled analog voltage becomes digital speed
// - Four-valued source select, analog or stored
// - Three contacts pick one of eight speeds
// - Reset defaults to the analog source
// - Stored speeds are signed, plus/minus 20000
// - Analog gain 10 to 2000 per volt
// - One bit inverts analog polarity
// - Signed offset added to analog input
// - First-order lag filter on analog input
// - One bit selects direction specifying method
// - Zero clamp forces command to zero
// - Four clamp modes, threshold for holding
// - Attained output when speed reaches level
// - Match output when speed near command
// - Acceleration time limits speed moving away from zero
// - Deceleration time limits speed moving toward zero
// - S-curve rounds ramp start and end
`default_nettype none

module vcp_core
  import vcp_pkg::*;
(
  input  wire logic              I_CLK,
  input  wire logic              I_RST_B,
  input  wire logic [7:0]        I_ADDR,
  input  wire logic [31:0]       I_WDATA,
  input  wire logic              I_WR,
  input  wire logic              I_RD,
  output logic      [31:0]       O_RDATA,
  input  wire logic signed [15:0] I_ANALOG_SPEED_CMD,
  input  wire logic signed [15:0] I_MOTOR_SPEED,
  input  wire logic              I_SPEED_SELECT_IN0,
  input  wire logic              I_SPEED_SELECT_IN1,
  input  wire logic              I_SPEED_SELECT_IN2,
  input  wire logic              I_ZERO_CLAMP_IN,
  input  wire logic              I_DIR_NEG,
  output logic signed [15:0]     O_SPEED_CMD,
  output logic                   O_ATTAINED_SPEED_OUT,
  output logic                   O_SPEED_MATCH_OUT,
  output logic                   O_POS_HOLD
);
  // Settings
  logic [CTRL_W-1:0]  ctrl_r, ctrl_nxt;       // Source, direction, invert, clamp mode
  logic [10:0]        gain_r, gain_nxt;       // Analog gain, r/min per volt
  logic signed [15:0] offs_r, offs_nxt;       // Analog offset, input steps
  logic [12:0]        tc_r, tc_nxt;           // Filter constant, 0.01 ms
  logic [15:0]        zthr_r, zthr_nxt;       // Clamp holding threshold
  logic [14:0]        match_r, match_nxt;     // Match window
  logic [14:0]        attain_r, attain_nxt;   // Attained level
  logic [13:0]        accel_r, accel_nxt;
  logic [13:0]        decel_r, decel_nxt;
  logic [9:0]         scurve_r, scurve_nxt;
  logic signed [15:0] int_spd_r [8];          // Stored speeds
  logic signed [15:0] int_spd_nxt [8];
  logic [31:0]        rdata_r, rdata_nxt;
  // Datapath
  logic [10:0]        cnt_r, cnt_nxt;         // Control period counter
  logic               tick;
  logic signed [31:0] xq;                     // Offset-corrected input, fractional
  logic signed [31:0] filt_r, filt_nxt;       // Filtered input, fractional
  logic signed [47:0] prod;
  logic signed [15:0] ana_spd;                // Analog speed after gain and polarity
  logic [2:0]         idx;                    // Contact index
  logic signed [15:0] sel_cmd, dir_cmd, target;
  logic [16:0]        sel_mag;
  logic               clamp_act;
  logic [1:0]         src, zmode;
  logic               att_r, att_nxt, match_o_r, match_o_nxt, hold_r, hold_nxt;
  logic [16:0]        abs_motor, abs_diff;

  vcp_ramp_if rif ();

  ////////////////////////////////////////////////////////////////////////
  // Helpers
  // Stored speed window occupies 0x40..0x5C
  function automatic logic is_int(input logic [7:0] a);
    return (a[7:5] == A_INT0[7:5]) && (a[1:0] == 2'h0);
  endfunction : is_int

  function automatic logic [16:0] abs17(input logic signed [16:0] v);
    return (v < 0) ? 17'(-v) : 17'(v);
  endfunction : abs17

  // Limit to the legal speed span
  function automatic logic signed [15:0] sat16(input logic signed [47:0] v);
    if (v > 48'(SPD_MAX)) begin
      return 16'(SPD_MAX);
    end else if (v < -48'(SPD_MAX)) begin
      return 16'(-SPD_MAX);
    end
    return 16'(v);
  endfunction : sat16

  ////////////////////////////////////////////////////////////////////////
  // Register writes and read data
  always_comb begin
    ctrl_nxt   = ctrl_r;
    gain_nxt   = gain_r;
    offs_nxt   = offs_r;
    tc_nxt     = tc_r;
    zthr_nxt   = zthr_r;
    match_nxt  = match_r;
    attain_nxt = attain_r;
    accel_nxt  = accel_r;
    decel_nxt  = decel_r;
    scurve_nxt = scurve_r;
    for (int k = 0; k < 8; k++) begin
      int_spd_nxt[k] = int_spd_r[k];
    end
    if (I_WR) begin
      case (I_ADDR)
        A_CTRL:   ctrl_nxt   = I_WDATA[CTRL_W-1:0];
        A_GAIN:   gain_nxt   = I_WDATA[10:0];
        A_OFFS:   offs_nxt   = I_WDATA[15:0];
        A_FILT:   tc_nxt     = I_WDATA[12:0];
        A_ZTHR:   zthr_nxt   = I_WDATA[15:0];
        A_MATCH:  match_nxt  = I_WDATA[14:0];
        A_ATTAIN: attain_nxt = I_WDATA[14:0];
        A_ACCEL:  accel_nxt  = I_WDATA[13:0];
        A_DECEL:  decel_nxt  = I_WDATA[13:0];
        A_SCURVE: scurve_nxt = I_WDATA[9:0];
        default: ;                                   // Status and unmapped: ignored
      endcase
      if (is_int(I_ADDR)) begin
        int_spd_nxt[I_ADDR[4:2]] = I_WDATA[15:0];
      end
    end
    // Unmapped reads return zero
    rdata_nxt = 32'h0000_0000;
    if (I_RD) begin
      case (I_ADDR)
        A_CTRL:   rdata_nxt = 32'(ctrl_r);
        A_GAIN:   rdata_nxt = 32'(gain_r);
        A_OFFS:   rdata_nxt = 32'(offs_r);
        A_FILT:   rdata_nxt = 32'(tc_r);
        A_ZTHR:   rdata_nxt = 32'(zthr_r);
        A_MATCH:  rdata_nxt = 32'(match_r);
        A_ATTAIN: rdata_nxt = 32'(attain_r);
        A_ACCEL:  rdata_nxt = 32'(accel_r);
        A_DECEL:  rdata_nxt = 32'(decel_r);
        A_SCURVE: rdata_nxt = 32'(scurve_r);
        A_STATUS: rdata_nxt = {26'h0, idx, hold_r, match_o_r, att_r};
        A_CMD:    rdata_nxt = 32'(O_SPEED_CMD);      // Sign-extended
        default:  rdata_nxt = is_int(I_ADDR) ? 32'(int_spd_r[I_ADDR[4:2]]) : 32'h0000_0000;
      endcase
    end
  end

  // Setting registers
  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      ctrl_r   <= RST_CTRL;
      gain_r   <= RST_GAIN;
      offs_r   <= 16'sh0000;
      tc_r     <= 13'h0000;
      zthr_r   <= 16'h0000;
      match_r  <= RST_MATCH;
      attain_r <= RST_ATTAIN;
      accel_r  <= 14'h0000;
      decel_r  <= 14'h0000;
      scurve_r <= 10'h000;
      rdata_r  <= 32'h0000_0000;
      for (int k = 0; k < 8; k++) begin
        int_spd_r[k] <= 16'sh0000;
      end
    end else begin
      ctrl_r   <= ctrl_nxt;
      gain_r   <= gain_nxt;
      offs_r   <= offs_nxt;
      tc_r     <= tc_nxt;
      zthr_r   <= zthr_nxt;
      match_r  <= match_nxt;
      attain_r <= attain_nxt;
      accel_r  <= accel_nxt;
      decel_r  <= decel_nxt;
      scurve_r <= scurve_nxt;
      rdata_r  <= rdata_nxt;
      int_spd_r <= int_spd_nxt;
    end
  end

  assign O_RDATA = rdata_r;

  ////////////////////////////////////////////////////////////////////////
  // Control period, analog filter and scaling
  always_comb begin
    tick    = (cnt_r == 11'(CTRL_CYC - 1));
    cnt_nxt = tick ? 11'h000 : cnt_r + 11'h001;
    // Wide intermediates: code times gain times scale overflows 32 bits
    xq   = (32'(I_ANALOG_SPEED_CMD) + 32'(offs_r)) <<< FRAC_BITS;
    filt_nxt = filt_r;
    if (tick) begin
      if (tc_r <= 13'(FILT_STEP)) begin
        filt_nxt = xq;
      end else begin
        // Divisor made signed: an unsigned one would turn falling inputs into huge steps
        filt_nxt = filt_r + (xq - filt_r) * FILT_STEP / $signed(32'(tc_r));
      end
    end
    // Gain widened as signed, so the product stays signed and the shift arithmetic
    prod    = (48'(filt_r >>> FRAC_BITS) * 48'($signed({1'b0, gain_r})) * 48'(SCALE_Q)) >>> SCALE_SH;
    ana_spd = ctrl_r[CF_INV] ? sat16(-prod) : sat16(prod);
  end

  // Filter and period registers
  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      cnt_r  <= 11'h000;
      filt_r <= 32'sh0;
    end else begin
      cnt_r  <= cnt_nxt;
      filt_r <= filt_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Source selection, direction, clamp and status
  always_comb begin
    src   = ctrl_r[CF_SRC +: 2];
    zmode = ctrl_r[CF_ZM +: 2];
    idx   = {I_SPEED_SELECT_IN2, I_SPEED_SELECT_IN1, I_SPEED_SELECT_IN0};
    unique case (src)
      SRC_ANALOG: sel_cmd = ana_spd;
      SRC_INT4:   sel_cmd = int_spd_r[{1'b0, idx[1:0]}];
      SRC_INT7:   sel_cmd = (idx == 3'h7) ? ana_spd : int_spd_r[idx];
      SRC_INT8:   sel_cmd = int_spd_r[idx];
    endcase
    // Method 1 takes magnitude from the command and sign from the contact
    sel_mag = abs17(17'(sel_cmd));
    if (ctrl_r[CF_DIR]) begin
      dir_cmd = I_DIR_NEG ? 16'(-sel_mag) : 16'(sel_mag);
    end else begin
      dir_cmd = sel_cmd;
    end
    clamp_act = I_ZERO_CLAMP_IN && (zmode != ZM_OFF);
    target    = clamp_act ? 16'sh0000 : dir_cmd;
    abs_motor = abs17(17'(I_MOTOR_SPEED));
    // Holding takes over only once speed falls to the threshold
    hold_nxt  = clamp_act &&
                ((zmode == ZM_MOTOR && abs_motor <= 17'(zthr_r)) ||
                 (zmode == ZM_CMD && abs17(17'(O_SPEED_CMD)) <= 17'(zthr_r)));
    att_nxt   = abs_motor >= 17'(attain_r);
    abs_diff  = abs17(17'(I_MOTOR_SPEED) - (ctrl_r[CF_MSRC] ? 17'(target) : 17'(O_SPEED_CMD)));
    match_o_nxt = abs_diff <= 17'(match_r);
  end

  // Status registers
  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      att_r     <= 1'b0;
      match_o_r <= 1'b0;
      hold_r    <= 1'b0;
    end else begin
      att_r     <= att_nxt;
      match_o_r <= match_o_nxt;
      hold_r    <= hold_nxt;
    end
  end

  assign O_ATTAINED_SPEED_OUT = att_r;
  assign O_SPEED_MATCH_OUT    = match_o_r;
  assign O_POS_HOLD           = hold_r;

  ////////////////////////////////////////////////////////////////////////
  // Ramp stage; zero times leave it transparent for an outer position loop
  assign rif.tick   = tick;
  assign rif.target = target;
  assign rif.accel  = accel_r;
  assign rif.decel  = decel_r;
  assign rif.scurve = scurve_r;
  assign O_SPEED_CMD = rif.speed;

  vcp_ramp u_ramp (
    .i_clk   (I_CLK),
    .i_rst_b (I_RST_B),
    .rif     (rif.rmp)
  );

  ////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_RST_B);

  src_analog_a: assert property (
    src == SRC_ANALOG && !clamp_act && !ctrl_r[CF_DIR] |-> target == ana_spd)
    else $error("analog source not selected");
  int_index_a: assert property (
    src == SRC_INT8 && !clamp_act && !ctrl_r[CF_DIR] |->
      target == int_spd_r[{I_SPEED_SELECT_IN2, I_SPEED_SELECT_IN1, I_SPEED_SELECT_IN0}])
    else $error("stored speed index mismatch");
  zero_clamp_a: assert property (
    I_ZERO_CLAMP_IN && zmode != ZM_OFF |-> target == 16'sh0000)
    else $error("clamped command not zero");
  filter_bypass_a: assert property (
    tick && tc_r <= 13'(FILT_STEP) |=> filt_r == $past(xq))
    else $error("filter did not pass input through");
  attained_a: assert property (
    1'b1 |=> O_ATTAINED_SPEED_OUT == ($past(abs_motor) >= 17'($past(attain_r))))
    else $error("attained output wrong");
  match_a: assert property (
    ctrl_r[CF_MSRC] && !I_WR |=> O_SPEED_MATCH_OUT ==
      (abs17($past(17'(I_MOTOR_SPEED)) - $past(17'(target))) <= 17'(match_r)))
    else $error("match output wrong");
  tick_period_a: assert property (
    tick |=> !tick [*8])
    else $error("control period too short");
endmodule : vcp_core

`default_nettype wire

// ===== testbench/vcp_host_model.sv
// Host controller model: analog code, motor speed feedback and contacts.
// Assumes the bench calls drive from one process only.
`default_nettype none

module vcp_host_model (
  input  wire logic               i_clk,
  output logic signed [15:0]      o_analog,
  output logic signed [15:0]      o_motor,
  output logic [2:0]              o_sel,
  output logic                    o_clamp,
  output logic                    o_dir_neg
);
  timeunit 1ns;
  timeprecision 100ps;

  // Quiet host at time zero: no command, contacts open
  initial begin
    o_analog  = 16'sh0000;
    o_motor   = 16'sh0000;
    o_sel     = 3'h0;
    o_clamp   = 1'b0;
    o_dir_neg = 1'b0;
  end

  // All lines move together just after an edge, so the block never sees a half-set contact code
  task automatic drive(input logic signed [15:0] ana, input logic signed [15:0] mot,
                       input logic [2:0] sel, input logic clamp, input logic dir);
    @(posedge i_clk);
    o_analog  <= ana;
    o_motor   <= mot;
    o_sel     <= sel;
    o_clamp   <= clamp;
    o_dir_neg <= dir;
  endtask : drive
endmodule : vcp_host_model

`default_nettype wire

// ===== testbench/tb_velocity_command_processor.sv
// Bench for the velocity command processor: bus tasks, scenarios, verdict.
// Assumes vcp_pkg, the ramp stage and vcp_core are compiled first.
`default_nettype none

module tb_velocity_command_processor import vcp_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;

  logic               clk = 1'b0;   // 20 MHz control clock
  logic               rst_b = 1'b0; // Active-low reset
  logic [7:0]         addr = 8'h00; // Bus address
  logic [31:0]        wdata = 32'h0;
  logic               wr = 1'b0;
  logic               rd = 1'b0;
  logic [31:0]        rdata;
  logic signed [15:0] ana, motor, spd;
  logic [2:0]         sel;
  logic               clamp, dir_neg, attained, match, hold;
  int                 errors = 0;   // Mismatches
  int                 checked = 0;  // Comparisons
  int                 cycles = 0;   // Hang guard
  logic signed [15:0] tbl [8] = '{16'shB1E0, 16'sh4E20, 16'sh0001, 16'shFFFF,
                                   16'sh012C, 16'sh1B58, 16'shFF85, 16'sh1000};

  always #25 clk = ~clk;

  vcp_host_model host_u (.i_clk(clk), .o_analog(ana), .o_motor(motor), .o_sel(sel),
                         .o_clamp(clamp), .o_dir_neg(dir_neg));

  vcp_core dut_u (.I_CLK(clk), .I_RST_B(rst_b), .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr),
    .I_RD(rd), .O_RDATA(rdata), .I_ANALOG_SPEED_CMD(ana), .I_MOTOR_SPEED(motor),
    .I_SPEED_SELECT_IN0(sel[0]), .I_SPEED_SELECT_IN1(sel[1]), .I_SPEED_SELECT_IN2(sel[2]),
    .I_ZERO_CLAMP_IN(clamp), .I_DIR_NEG(dir_neg), .O_SPEED_CMD(spd),
    .O_ATTAINED_SPEED_OUT(attained), .O_SPEED_MATCH_OUT(match), .O_POS_HOLD(hold));

  ////////////////////////////////////////////////////////////////////////////////
  // Compare, bus and wait helpers

  task automatic cmp_reg(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("Error t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp_reg

  task automatic cmp_spd(input logic signed [15:0] got, input logic signed [15:0] exp);
    cmp_reg({16'h0, got}, {16'h0, exp});
  endtask : cmp_spd

  task automatic cmp_bit(input logic got, input logic exp);
    cmp_reg({31'h0, got}, {31'h0, exp});
  endtask : cmp_bit

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask : wr_reg

  // Read data stand only in the cycle after the strobe
  task automatic rd_reg(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1;
    cmp_reg(rdata, exp);
  endtask : rd_reg

  // Whole control periods plus a small margin for the register stage
  task automatic settle(input int n);
    repeat (n * CTRL_CYC + 5) @(posedge clk);
    #1;
  endtask : settle

  // Bounded wait for the next ramp update
  task automatic next_step;
    logic signed [15:0] old;
    int                 n;
    old = spd;
    n = 0;
    while (spd === old && n < 2 * CTRL_CYC) begin
      @(posedge clk);
      #1;
      n++;
    end
  endtask : next_step

  function automatic logic signed [15:0] ana_exp(input longint code, input longint gain);
    return 16'((code * gain * SCALE_Q) >>> SCALE_SH);
  endfunction : ana_exp

  ////////////////////////////////////////////////////////////////////////////////
  // Scenarios

  task automatic t_reset_vals;
    cmp_spd(spd, 16'sh0000);
    rd_reg(A_CTRL, 32'h0);
    rd_reg(A_GAIN, 32'h1F4);
    rd_reg(A_MATCH, 32'h32);
    rd_reg(A_ATTAIN, 32'h3E8);
    rd_reg(8'h30, 32'h0);              // Unmapped reads as zero
  endtask : t_reset_vals

  task automatic t_stored;
    wr_reg(A_CTRL, {30'h0, SRC_INT8});
    wr_reg(A_ACCEL, 32'h0);
    wr_reg(A_DECEL, 32'h0);
    for (int i = 0; i < 8; i++) begin
      wr_reg(8'(A_INT0 + 4 * i), {{16{tbl[i][15]}}, tbl[i]});
    end
    rd_reg(A_INT0, 32'hFFFFB1E0);
    for (int i = 0; i < 8; i++) begin
      host_u.drive(16'sh0000, 16'sh0000, 3'(i), 1'b0, 1'b0);
      settle(1);
      cmp_spd(spd, tbl[i]);
    end
    wr_reg(A_CTRL, {30'h0, SRC_INT4});
    host_u.drive(16'sh0000, 16'sh0000, 3'h5, 1'b0, 1'b0);
    settle(1);
    cmp_spd(spd, tbl[1]);
    // Index 7 under the seven-speed source falls back to the analog path, here at zero
    wr_reg(A_CTRL, {30'h0, SRC_INT7});
    host_u.drive(16'sh0000, 16'sh0000, 3'h7, 1'b0, 1'b0);
    settle(1);
    cmp_spd(spd, 16'sh0000);
  endtask : t_stored

  task automatic t_dir;
    wr_reg(A_CTRL, 32'h3 | (32'h1 << CF_DIR));
    host_u.drive(16'sh0000, 16'sh0000, 3'h4, 1'b0, 1'b1);
    settle(2);
    cmp_spd(spd, 16'shFED4);
    host_u.drive(16'sh0000, 16'sh0000, 3'h3, 1'b0, 1'b0);
    settle(2);
    cmp_spd(spd, 16'sh0001);
  endtask : t_dir

  task automatic t_clamp;
    wr_reg(A_CTRL, {30'h0, SRC_INT8});
    host_u.drive(16'sh0000, 16'sh0032, 3'h4, 1'b1, 1'b0);
    settle(2);
    cmp_spd(spd, 16'sh012C);
    wr_reg(A_ZTHR, 32'h64);
    wr_reg(A_CTRL, 32'h3 | (32'(ZM_MOTOR) << CF_ZM));
    settle(2);
    cmp_spd(spd, 16'sh0000);
    cmp_bit(hold, 1'b1);
    host_u.drive(16'sh0000, 16'sh0096, 3'h4, 1'b1, 1'b0);
    repeat (3) @(posedge clk);
    #1;
    cmp_bit(hold, 1'b0);
    // Command-based holding ignores the motor speed that blocked the motor-based mode
    wr_reg(A_CTRL, 32'h3 | (32'(ZM_CMD) << CF_ZM));
    repeat (3) @(posedge clk);
    #1;
    cmp_bit(hold, 1'b1);
    host_u.drive(16'sh0000, 16'sh0000, 3'h4, 1'b0, 1'b0);
    settle(2);
    cmp_spd(spd, 16'sh012C);
  endtask : t_clamp

  // Leaves the output resting at 300
  task automatic t_ramp;
    int up;
    int dn;
    up = (RAMP_NUM / 1) >>> FRAC_BITS;
    dn = (RAMP_NUM / 2) >>> FRAC_BITS;
    wr_reg(A_CTRL, {30'h0, SRC_INT8});
    wr_reg(A_ACCEL, 32'h1);
    wr_reg(A_DECEL, 32'h2);
    host_u.drive(16'sh0000, 16'sh0000, 3'h7, 1'b0, 1'b0);
    next_step();
    cmp_spd(spd, 16'(300 + up));
    next_step();
    cmp_spd(spd, 16'(300 + 2 * up));
    host_u.drive(16'sh0000, 16'sh0000, 3'h4, 1'b0, 1'b0);
    next_step();
    cmp_spd(spd, 16'(300 + 2 * up - dn));
    wr_reg(A_ACCEL, 32'h0);
    wr_reg(A_DECEL, 32'h0);
    settle(2);
    // One ms of rounding: the first tick only arms the lag, the second moves a tenth of the gap
    wr_reg(A_SCURVE, 32'h1);
    host_u.drive(16'sh0000, 16'sh0000, 3'h7, 1'b0, 1'b0);
    next_step();
    cmp_spd(spd, 16'(((300 << FRAC_BITS) + (3796 << FRAC_BITS) / MS_PER) >>> FRAC_BITS));
    wr_reg(A_SCURVE, 32'h0);
    host_u.drive(16'sh0000, 16'sh0000, 3'h4, 1'b0, 1'b0);
    settle(2);
  endtask : t_ramp

  // Boundaries of both status windows around a command of 300
  task automatic t_status;
    logic signed [15:0] mv [7] = '{16'sh03E8, 16'sh03E7, 16'shFC18, 16'sh015E,
                                    16'sh015F, 16'sh00FA, 16'sh00F9};
    logic               ea [7] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0};
    logic               em [7] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
    for (int i = 0; i < 7; i++) begin
      host_u.drive(16'sh0000, mv[i], 3'h4, 1'b0, 1'b0);
      repeat (3) @(posedge clk);
      #1;
      cmp_bit(attained, ea[i]);
      cmp_bit(match, em[i]);
    end
    // Match against the unramped command: a near-frozen ramp keeps the output far away
    wr_reg(A_ACCEL, 32'h2710);
    wr_reg(A_CTRL, 32'h3 | (32'h1 << CF_MSRC));
    host_u.drive(16'sh0000, 16'sh1000, 3'h7, 1'b0, 1'b0);
    repeat (3) @(posedge clk);
    #1;
    cmp_bit(match, 1'b1);
    wr_reg(A_ACCEL, 32'h0);
  endtask : t_status

  task automatic t_analog;
    wr_reg(A_CTRL, 32'h0);
    host_u.drive(16'sh15CA, 16'sh0000, 3'h0, 1'b0, 1'b0);
    settle(2);
    cmp_spd(spd, ana_exp(5578, 500));
    wr_reg(A_CTRL, 32'h1 << CF_INV);
    settle(2);
    cmp_spd(spd, -ana_exp(5578, 500));
    wr_reg(A_CTRL, 32'h0);
    wr_reg(A_OFFS, 32'h15CA);
    // Negative sum exercises the signed scaling path
    host_u.drive(16'shD46C, 16'sh0000, 3'h0, 1'b0, 1'b0);
    settle(2);
    cmp_spd(spd, ana_exp(-5578, 500));
    wr_reg(A_OFFS, 32'h0);
    wr_reg(A_GAIN, 32'h7D0);
    host_u.drive(16'sh7FFF, 16'sh0000, 3'h0, 1'b0, 1'b0);
    settle(2);
    cmp_spd(spd, 16'sh4E20);
    wr_reg(A_GAIN, 32'h1F4);
    // Reach zero with the filter bypassed, so the lag starts from an exact zero
    host_u.drive(16'sh0000, 16'sh0000, 3'h0, 1'b0, 1'b0);
    settle(2);
    wr_reg(A_FILT, 32'h14);
    host_u.drive(16'sh15CA, 16'sh0000, 3'h0, 1'b0, 1'b0);
    next_step();
    cmp_spd(spd, ana_exp(2789, 500));
  endtask : t_analog

  ////////////////////////////////////////////////////////////////////////////////
  // Verdict, hang guard and main sequence

  task automatic give_verdict;
    $display("Comparisons %0d, errors %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : give_verdict

  // Tests need about 82000 cycles; the ceiling leaves margin
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 95000) begin
      errors = errors + 1;
      give_verdict();
    end
  end

  initial begin : main
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    #1;
    t_reset_vals();
    t_stored();
    t_dir();
    t_clamp();
    t_ramp();
    t_status();
    t_analog();
    give_verdict();
  end
endmodule : tb_velocity_command_processor

`default_nettype wire
